// ===== design/rcdfr_top.sv
// Reset cause status register and background debug force reset control
`timescale 1ns/10ps
`include "rcdfr_consts.svh"

module rcdfr_top #(
    parameter int HOLD_CYC = `RCDFR_HOLD_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_wr_from_bdc,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_lv_trip,
    input wire logic i_low_voltage_reset_enable,
    input wire logic i_reset_pin_n,
    input wire logic i_wdog_timeout,
    input wire logic i_watchdog_enable,
    input wire logic i_undef_opcode,
    input wire logic i_stop_exec,
    input wire logic i_stop_enable,
    input wire logic i_background_instruction_exec,
    input wire logic i_background_mode_enable,
    input wire logic i_illegal_addr,
    input wire logic i_background_mode_select_pin,
    output logic [7:0] o_rdata,
    output logic o_wdog_restart,
    output logic o_sys_reset,
    output logic o_active_background_mode
);
    import rcdfr_pkg::*;

    // Upper limit keeps the hold check inside a plain delay range
    if (HOLD_CYC < 1 || HOLD_CYC > 1000) begin
        $error("reset hold must last between one and 1000 cycles");
    end

    rcdfr_state_t state_q;
    rcdfr_state_t state_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wdog_restart_q;
    logic wdog_restart_d;
    logic sys_reset_q;
    logic sys_reset_d;
    logic abm_q;
    logic abm_d;

    logic src_lowv;
    logic src_pin;
    logic src_wdog;
    logic src_badop;
    logic src_badaddr;
    logic src_other;
    logic status_wr;
    logic force_wr;
    logic entry;
    logic hold_done;

    // Qualified reset sources
    assign src_lowv = i_lv_trip & i_low_voltage_reset_enable;
    assign src_pin = ~i_reset_pin_n;
    assign src_wdog = i_wdog_timeout & i_watchdog_enable;
    assign src_badop = i_undef_opcode | (i_stop_exec & ~i_stop_enable)
                     | (i_background_instruction_exec & ~i_background_mode_enable);
    assign src_badaddr = i_illegal_addr;
    assign src_other = src_pin | src_wdog | src_badop | src_badaddr;

    assign status_wr = i_wr & (i_addr == `RCDFR_STATUS_OFS);
    // User program writes never reach the force bit
    assign force_wr = i_wr & i_wr_from_bdc & (i_addr == `RCDFR_FORCE_OFS)
                    & i_wdata[`RCDFR_FORCE_BIT];

    // Sources are sampled only on entry; those seen during the hold are ignored
    assign entry = (state_q == RCDFR_ST_RUN) & (src_lowv | src_other | force_wr);

    rcdfr_hold_timer #(
        .HOLD_CYC(HOLD_CYC)
    ) u_hold (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_start(entry),
        .o_done(hold_done)
    );

    // Reset sequencing and cause capture
    always_comb begin
        state_d = state_q;
        status_d = status_q;
        abm_d = abm_q;
        unique case (state_q)
            RCDFR_ST_RUN: begin
                if (entry) begin
                    state_d = RCDFR_ST_HOLD;
                    if (src_lowv) begin
                        status_d = `RCDFR_STATUS_LOWV;
                    end else if (src_other) begin
                        status_d = 8'h00;
                        status_d[`RCDFR_PIN_BIT] = src_pin;
                        status_d[`RCDFR_WDOG_BIT] = src_wdog;
                        status_d[`RCDFR_BADOP_BIT] = src_badop;
                        status_d[`RCDFR_BADADDR_BIT] = src_badaddr;
                    end else begin
                        status_d = `RCDFR_STATUS_FORCED;
                    end
                end
            end
            RCDFR_ST_HOLD: begin
                if (hold_done) begin
                    state_d = RCDFR_ST_RUN;
                    // Mode pin level at release picks user or background mode
                    abm_d = ~i_background_mode_select_pin;
                end
            end
        endcase
        sys_reset_d = (state_d == RCDFR_ST_HOLD);
    end

    // Register reads and watchdog restart
    always_comb begin
        rdata_d = rdata_q;
        if (i_rd) begin
            if (i_addr == `RCDFR_STATUS_OFS) begin
                rdata_d = status_q & `RCDFR_STATUS_MASK;
            end else if (i_addr == `RCDFR_FORCE_OFS) begin
                rdata_d = `RCDFR_FORCE_READ;
            end else begin
                rdata_d = 8'h00;
            end
        end
        wdog_restart_d = status_wr;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q <= RCDFR_ST_RUN;
            status_q <= `RCDFR_STATUS_POR;
            rdata_q <= 8'h00;
            wdog_restart_q <= 1'b0;
            sys_reset_q <= 1'b0;
            abm_q <= 1'b0;
        end else begin
            state_q <= state_d;
            status_q <= status_d;
            rdata_q <= rdata_d;
            wdog_restart_q <= wdog_restart_d;
            sys_reset_q <= sys_reset_d;
            abm_q <= abm_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_wdog_restart = wdog_restart_q;
    assign o_sys_reset = sys_reset_q;
    assign o_active_background_mode = abm_q;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // Flags move only on entry; checks key off entry, a bus strobe, reset release, the rise of the reset request, the hold state or nothing
    chk_status_read_mask: assert property (
        i_rd && i_addr == `RCDFR_STATUS_OFS |=> o_rdata == ($past(status_q) & `RCDFR_STATUS_MASK))
        else $error("status read does not show the stored flags");
    chk_unmapped_read_zero: assert property (
        i_rd && i_addr != `RCDFR_STATUS_OFS && i_addr != `RCDFR_FORCE_OFS |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (
        !i_rd |=> $stable(o_rdata))
        else $error("read data changed without a read");
    chk_forced_clears_all: assert property (
        entry && force_wr && !src_lowv && !src_other |=> status_q == 8'h00 && o_sys_reset)
        else $error("forced reset left flags set");
    chk_status_wr_restart: assert property (
        status_wr && !entry |=> o_wdog_restart && $stable(status_q))
        else $error("status write did not restart the watchdog or changed flags");
    chk_other_wr_quiet: assert property (
        !(i_wr && i_addr == `RCDFR_STATUS_OFS) |=> !o_wdog_restart)
        else $error("watchdog restart without a status write");
    chk_por_value: assert property (
        $rose(i_rst_n) |-> status_q == `RCDFR_STATUS_POR)
        else $error("power-on value wrong");
    chk_lowv_value: assert property (
        entry && src_lowv |=> status_q == `RCDFR_STATUS_LOWV)
        else $error("low-voltage reset value wrong");
    chk_pin_flag: assert property (
        entry && !src_lowv && src_other |=> status_q[`RCDFR_PIN_BIT] == $past(src_pin))
        else $error("pin flag does not follow the pin source");
    chk_wdog_flag_follows: assert property (
        entry && !src_lowv && src_other |=> status_q[`RCDFR_WDOG_BIT] == $past(src_wdog))
        else $error("watchdog flag does not follow the watchdog source");
    chk_wdog_blocked: assert property (
        entry && !i_watchdog_enable && !src_lowv |=> !status_q[`RCDFR_WDOG_BIT])
        else $error("watchdog flag set while watchdog disabled");
    chk_stop_badop: assert property (
        entry && !src_lowv && i_stop_exec && !i_stop_enable |=> status_q[`RCDFR_BADOP_BIT])
        else $error("disabled stop did not set the illegal opcode flag");
    chk_instr_badop: assert property (
        entry && !src_lowv && i_background_instruction_exec && !i_background_mode_enable
        |=> status_q[`RCDFR_BADOP_BIT])
        else $error("disabled background instruction did not set the illegal opcode flag");
    chk_badaddr_flag: assert property (
        entry && !src_lowv && src_badaddr |=> status_q[`RCDFR_BADADDR_BIT])
        else $error("illegal address flag missing");
    chk_user_force_ignored: assert property (
        state_q == RCDFR_ST_RUN && i_wr && !i_wr_from_bdc && !src_lowv && !src_other |=> !o_sys_reset)
        else $error("user write forced a reset");
    chk_force_reads_zero: assert property (
        i_rd && i_addr == `RCDFR_FORCE_OFS |=> o_rdata == 8'h00)
        else $error("force register read not zero");
    chk_reset_hold_ends: assert property (
        $rose(o_sys_reset) |-> o_sys_reset [*2] ##[0:HOLD_CYC] !o_sys_reset)
        else $error("reset request did not end");
    chk_mode_pin_sample: assert property (
        state_q == RCDFR_ST_HOLD && hold_done |=> o_active_background_mode == !$past(i_background_mode_select_pin))
        else $error("mode after reset does not follow the mode pin");
    chk_reserved_zero: assert property (
        status_q[2] == 1'b0 && status_q[0] == 1'b0)
        else $error("reserved status bit set");
    chk_hold_flags_stable: assert property (
        state_q == RCDFR_ST_HOLD |=> $stable(status_q))
        else $error("flags changed during hold");
    chk_flags_hold: assert property (
        !entry |=> $stable(status_q))
        else $error("flags changed without a reset entry");

    cov_forced_reset: cover property (force_wr && entry);
    cov_pin_reset: cover property (entry && src_pin && !src_lowv);
    cov_abm_entry: cover property ($rose(o_active_background_mode));
    cov_status_restart: cover property (status_wr && state_q == RCDFR_ST_RUN);
    cov_lowv_reset: cover property (entry && src_lowv);
endmodule

// ===== include/rcdfr_consts.svh
// Offsets, field positions, reset values and timing counts of the reset cause block
`ifndef RCDFR_CONSTS_SVH
`define RCDFR_CONSTS_SVH

`define RCDFR_STATUS_OFS 8'h00
`define RCDFR_FORCE_OFS 8'h01

`define RCDFR_POR_BIT 7
`define RCDFR_PIN_BIT 6
`define RCDFR_WDOG_BIT 5
`define RCDFR_BADOP_BIT 4
`define RCDFR_BADADDR_BIT 3
`define RCDFR_LOWV_BIT 1
`define RCDFR_FORCE_BIT 0

`define RCDFR_STATUS_POR 8'h82
`define RCDFR_STATUS_LOWV 8'h02
`define RCDFR_STATUS_FORCED 8'h00
`define RCDFR_STATUS_MASK 8'hfa
`define RCDFR_FORCE_READ 8'h00

`define RCDFR_CLK_NS 25
`define RCDFR_HOLD_NS 500
`define RCDFR_HOLD_CYC ((`RCDFR_HOLD_NS + `RCDFR_CLK_NS - 1) / `RCDFR_CLK_NS)

`endif

// ===== include/rcdfr_pkg.sv
// Types shared by the reset cause block
package rcdfr_pkg;

    typedef enum logic [0:0] {
        RCDFR_ST_RUN = 1'b0,
        RCDFR_ST_HOLD = 1'b1
    } rcdfr_state_t;

endpackage

// ===== design/rcdfr_hold_timer.sv
// Down counter that times how long the system reset request is held
`timescale 1ns/10ps
module rcdfr_hold_timer #(
    parameter int HOLD_CYC = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    output logic o_done
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    if (HOLD_CYC < 1) begin
        $error("hold count must be at least one cycle");
    end

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;

    always_comb begin
        count_d = count_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (i_start) begin
            count_d = CW'(HOLD_CYC - 1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (count_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                count_d = count_q - CW'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;
endmodule

// ===== tb/rcdfr_host_model.sv
// Debug host model that forces resets over the background link
`timescale 1ns/10ps
`include "rcdfr_consts.svh"
module rcdfr_host_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_reset,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_mode_pin
);
    initial begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_mode_pin = 1'b1;
    end
    task automatic force_reset(input logic mode);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        o_wr = 1'b1;
        o_addr = `RCDFR_FORCE_OFS;
        o_wdata = 8'h01;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        o_addr = 8'ha5;
        o_wdata = 8'hfe;
        o_mode_pin = mode;
        // Pin held until the reset request ends, then back to its pull-up level
        while (i_sys_reset === 1'b1 && n < 40) begin
            @(negedge i_clk_sys);
            n++;
        end
        o_mode_pin = 1'b1;
    endtask
endmodule

// ===== tb/rcdfr_top_tb.sv
// Self-checking bench of the reset cause and force reset block
`timescale 1ns/10ps
`include "rcdfr_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rcdfr_top_tb;
    import rcdfr_pkg::*;
    localparam int HOLD = 2;
    localparam logic [10:0] SRC_V [13] = '{11'h001, 11'h006, 11'h002, 11'h010, 11'h030, 11'h101, 11'h008,
        11'h100, 11'h040, 11'h0c0, 11'h600, 11'h200, 11'h601};
    localparam logic [7:0] SRC_E [13] = '{8'h40, 8'h20, 8'h20, 8'h10, 8'h10, 8'h48, 8'h10, 8'h08, 8'h10,
        8'h10, 8'h02, 8'h02, 8'h02};
    localparam logic [12:0] SRC_R = 13'b1010111101011;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic tb_wr = 1'b0, i_rd = 1'b0, h_wr, mode_pin, o_wdog_restart, o_sys_reset, o_abm;
    logic [7:0] tb_addr = 8'h00, tb_wdata = 8'h00, h_addr, h_wdata, o_rdata, rd_v;
    logic [10:0] src_v = 11'h4a4;
    int failures = 0, compares = 0, hi;
    always #12.5 i_clk_sys = ~i_clk_sys;
    rcdfr_top #(.HOLD_CYC(HOLD)) dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_addr(h_wr ? h_addr : tb_addr), .i_wr(tb_wr | h_wr), .i_wr_from_bdc(h_wr),
        .i_wdata(h_wr ? h_wdata : tb_wdata), .i_rd(i_rd), .i_reset_pin_n(~src_v[0]),
        .i_wdog_timeout(src_v[1]), .i_watchdog_enable(src_v[2]), .i_undef_opcode(src_v[3]),
        .i_stop_exec(src_v[4]), .i_stop_enable(src_v[5]), .i_background_instruction_exec(src_v[6]),
        .i_background_mode_enable(src_v[7]), .i_illegal_addr(src_v[8]), .i_lv_trip(src_v[9]),
        .i_low_voltage_reset_enable(src_v[10]), .i_background_mode_select_pin(mode_pin),
        .o_rdata(o_rdata), .o_wdog_restart(o_wdog_restart), .o_sys_reset(o_sys_reset),
        .o_active_background_mode(o_abm));
    rcdfr_host_model host_u (.i_clk_sys(i_clk_sys), .i_sys_reset(o_sys_reset), .o_wr(h_wr),
        .o_addr(h_addr), .o_wdata(h_wdata), .o_mode_pin(mode_pin));
    task automatic rd(input logic [7:0] a);
        @(negedge i_clk_sys);
        i_rd = 1'b1;
        tb_addr = a;
        @(negedge i_clk_sys);
        i_rd = 1'b0;
        rd_v = o_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        tb_wr = 1'b1;
        tb_addr = a;
        tb_wdata = d;
        @(negedge i_clk_sys);
        tb_wr = 1'b0;
    endtask
    // Counts cycles of the reset request; zero means none came
    task automatic wait_rst();
        int n;
        n = 0;
        hi = 0;
        while (o_sys_reset !== 1'b1 && n < 6) begin
            @(negedge i_clk_sys);
            n++;
        end
        while (o_sys_reset === 1'b1 && hi < 40) begin
            @(negedge i_clk_sys);
            hi++;
        end
    endtask
    task automatic t_por();
        rd(`RCDFR_STATUS_OFS);
        `CHK(rd_v, `RCDFR_STATUS_POR)
        `CHK(o_abm, 1'b0)
        rd(`RCDFR_FORCE_OFS);
        `CHK(rd_v, `RCDFR_FORCE_READ)
        rd(8'h37);
        `CHK(rd_v, 8'h00)
        $display("test por done");
    endtask
    task automatic t_status_write();
        wr(`RCDFR_STATUS_OFS, 8'hff);
        `CHK(o_wdog_restart, 1'b1)
        @(negedge i_clk_sys);
        `CHK(o_wdog_restart, 1'b0)
        wr(`RCDFR_STATUS_OFS, 8'h00);
        `CHK(o_wdog_restart, 1'b1)
        rd(`RCDFR_STATUS_OFS);
        `CHK(rd_v, `RCDFR_STATUS_POR)
        $display("test status write done");
    endtask
    task automatic t_user_force();
        wr(`RCDFR_FORCE_OFS, 8'hff);
        `CHK(o_wdog_restart, 1'b0)
        wait_rst();
        `CHK(hi, 0)
        rd(`RCDFR_FORCE_OFS);
        `CHK(rd_v, `RCDFR_FORCE_READ)
        $display("test user force done");
    endtask
    task automatic t_sources();
        for (int i = 0; i < 13; i++) begin
            @(negedge i_clk_sys);
            src_v = SRC_V[i];
            @(negedge i_clk_sys);
            src_v = SRC_V[i] & 11'h4a4;
            wait_rst();
            `CHK(hi, SRC_R[i] ? HOLD + 1 : 0)
            rd(`RCDFR_STATUS_OFS);
            `CHK(rd_v, SRC_E[i])
        end
        $display("test sources done");
    endtask
    task automatic t_forced(input logic mode);
        fork
            host_u.force_reset(mode);
            wait_rst();
        join
        `CHK(hi, HOLD + 1)
        `CHK(o_abm, ~mode)
        rd(`RCDFR_STATUS_OFS);
        `CHK(rd_v, `RCDFR_STATUS_FORCED)
        rd(`RCDFR_FORCE_OFS);
        `CHK(rd_v, `RCDFR_FORCE_READ)
        $display("test forced done");
    endtask
    task automatic finish_test();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        t_por();
        t_status_write();
        t_user_force();
        t_sources();
        t_forced(1'b0);
        t_forced(1'b1);
        finish_test();
    end
endmodule
